// >>> bench/ffp_fault_fsm_sva.sv
// ffp_fault_fsm_sva: port-level assertions for the fault supervision block
// assumes bind onto ffp_fault_fsm; all checks in the clk domain
`timescale 1ns/1ps
`default_nettype none
module ffp_fault_fsm_sva (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       low_side_pulse,
    input wire logic       cycle_tick,
    input wire logic       overcurrent_trip,
    input wire logic       short_circuit_trip,
    input wire logic       active_clamp_mode,
    input wire logic       discontinuous_mode,
    input wire logic       mode_handover,
    input wire logic       high_freq_band,
    input wire logic       vcc_on_level,
    input wire logic       vcc_off_level,
    input wire logic       thermal_trip,
    input wire logic       low_side_gate,
    input wire logic       clamp_gate,
    input wire logic       bias_charge_current,
    input wire logic       overcurrent_error,
    input wire logic [1:0] oc_level_sel,
    input wire logic       short_level_raised,
    input wire logic       per_cycle_limit,
    input wire logic       fault_latched,
    input wire logic       soft_start_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_hand;
        mode_handover && low_side_pulse;
    endsequence
    sequence s_raised;
        oc_level_sel == ffp_pkg::OC_LVL_RAISED && short_level_raised;
    endsequence
    cut_gate_a: assert property (per_cycle_limit |-> !low_side_gate) else $error("gate on during cut");
    cut_cause_a: assert property ($rose(per_cycle_limit) |-> $past(overcurrent_trip || short_circuit_trip))
        else $error("cut without trip");
    raise_lvl_a: assert property (s_hand |-> ##[1:2] s_raised) else $error("levels not raised");
    raise_pair_a: assert property ((oc_level_sel == ffp_pkg::OC_LVL_RAISED) == short_level_raised)
        else $error("raised levels split");
    dcm_lvl_a: assert property (discontinuous_mode && !active_clamp_mode && !mode_handover
        |=> oc_level_sel == ffp_pkg::OC_LVL_DCM || short_level_raised) else $error("bad dcm level");
    acf_lvl_a: assert property (active_clamp_mode && !discontinuous_mode && !mode_handover && !high_freq_band
        |=> oc_level_sel == ffp_pkg::OC_LVL_ACF || short_level_raised) else $error("bad clamp level");
    err_tick_a: assert property ($rose(overcurrent_error) |-> $past(cycle_tick)) else $error("flag off tick");
    latch_hold_a: assert property (fault_latched |=> fault_latched) else $error("latch dropped");
    latch_off_a: assert property (fault_latched && cycle_tick |-> ##2 !low_side_gate && !clamp_gate)
        else $error("gate on while latched");
    bias_on_a: assert property (fault_latched && vcc_off_level && !vcc_on_level |=> bias_charge_current)
        else $error("charge not on");
    bias_off_a: assert property (fault_latched && vcc_on_level |=> !bias_charge_current)
        else $error("charge not off");
    therm_off_a: assert property (thermal_trip [*3] |-> !low_side_gate && !clamp_gate)
        else $error("gate on in thermal");
    ss_cause_a: assert property ($rose(soft_start_req) |-> $past(vcc_on_level)) else $error("restart early");
endmodule
bind ffp_fault_fsm ffp_fault_fsm_sva u_sva (.clk(clk), .sys_rst(sys_rst), .low_side_pulse(low_side_pulse),
    .cycle_tick(cycle_tick), .overcurrent_trip(overcurrent_trip), .short_circuit_trip(short_circuit_trip),
    .active_clamp_mode(active_clamp_mode), .discontinuous_mode(discontinuous_mode), .mode_handover(mode_handover),
    .high_freq_band(high_freq_band), .vcc_on_level(vcc_on_level), .vcc_off_level(vcc_off_level),
    .thermal_trip(thermal_trip), .low_side_gate(low_side_gate), .clamp_gate(clamp_gate),
    .bias_charge_current(bias_charge_current), .overcurrent_error(overcurrent_error), .oc_level_sel(oc_level_sel),
    .short_level_raised(short_level_raised), .per_cycle_limit(per_cycle_limit), .fault_latched(fault_latched),
    .soft_start_req(soft_start_req));
`default_nettype wire

// >>> bench/tb_top.sv
// tb_top: directed bench for the fault supervision block
// assumes shortened full count, retry and hold parameters
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk, sys_rst, low_side_pulse, clamp_pulse, cycle_tick, overcurrent_trip, short_circuit_trip;
    logic       active_clamp_mode, discontinuous_mode, skip_mode, mode_handover, high_freq_band, vcc_on_level;
    logic       vcc_off_level, high_voltage_input, thermal_trip, oc_reaction_latch, short_reaction_latch;
    logic       short_limit_enable, low_side_gate, clamp_gate, bias_charge_current, overcurrent_error;
    logic       short_level_raised, per_cycle_limit, fault_latched, soft_start_req;
    logic [1:0] oc_level_sel;
    int         err_total, n_tests, cyc_cnt;

    ffp_fault_fsm #(.OC_FULL(6), .SHORT_LIMIT(2), .RETRY_CYCLES(20), .HOLD_CYCLES(10)) dut (.clk(clk),
        .sys_rst(sys_rst), .low_side_pulse(low_side_pulse), .clamp_pulse(clamp_pulse), .cycle_tick(cycle_tick),
        .overcurrent_trip(overcurrent_trip), .short_circuit_trip(short_circuit_trip), .skip_mode(skip_mode),
        .active_clamp_mode(active_clamp_mode), .discontinuous_mode(discontinuous_mode), .mode_handover(mode_handover),
        .high_freq_band(high_freq_band), .vcc_on_level(vcc_on_level), .vcc_off_level(vcc_off_level),
        .high_voltage_input(high_voltage_input), .thermal_trip(thermal_trip), .oc_reaction_latch(oc_reaction_latch),
        .short_reaction_latch(short_reaction_latch), .short_limit_enable(short_limit_enable),
        .low_side_gate(low_side_gate), .clamp_gate(clamp_gate), .bias_charge_current(bias_charge_current),
        .overcurrent_error(overcurrent_error), .oc_level_sel(oc_level_sel), .short_level_raised(short_level_raised),
        .per_cycle_limit(per_cycle_limit), .fault_latched(fault_latched), .soft_start_req(soft_start_req));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic rst();
        tk(1);
        sys_rst <= 1'b1;
        tk(5);
        sys_rst <= 1'b0;
        tk(1);
    endtask

    // one switching cycle; a trip lands well after both blanking windows
    task automatic pc(input logic oc, input logic sc);
        tk(1);
        low_side_pulse <= 1'b1;
        tk(18);
        overcurrent_trip <= oc;
        short_circuit_trip <= sc;
        tk(3);
        if (oc | sc) begin
            #1 chk("per_cycle_limit", 2'h1, 2'(per_cycle_limit));
            chk("low_side_gate", 2'h0, 2'(low_side_gate));
            tk(1);
        end
        {low_side_pulse, overcurrent_trip, short_circuit_trip} <= 3'h0;
        tk(1);
        cycle_tick <= 1'b1;
        tk(1);
        cycle_tick <= 1'b0;
        tk(2);
    endtask

    task automatic wait_ss();
        int i = 0;
        while (soft_start_req !== 1'b1 && i < 8) begin
            tk(1);
            #1 i++;
        end
        chk("soft_start_req", 2'h1, 2'(soft_start_req));
    endtask

    initial begin
        {err_total, n_tests, cyc_cnt} = '0;
        {low_side_pulse, clamp_pulse, cycle_tick, overcurrent_trip, short_circuit_trip, active_clamp_mode} = 6'h0;
        {skip_mode, mode_handover, high_freq_band, vcc_on_level, vcc_off_level, thermal_trip} = 6'h0;
        {sys_rst, discontinuous_mode, high_voltage_input, oc_reaction_latch} = 4'hf;
        {short_reaction_latch, short_limit_enable} = 2'h3;
        rst();
        pc(1'b1, 1'b0);
        #1 chk("overcurrent_error", 2'h1, 2'(overcurrent_error));
        chk("oc_level_sel", 2'h0, oc_level_sel);
        pc(1'b0, 1'b0);
        #1 chk("overcurrent_error", 2'h0, 2'(overcurrent_error));
        pc(1'b1, 1'b0);
        pc(1'b1, 1'b0);
        #1 chk("fault_latched", 2'h0, 2'(fault_latched));
        pc(1'b1, 1'b0);
        pc(1'b0, 1'b0);
        #1 chk("fault_latched", 2'h1, 2'(fault_latched));
        tk(1);
        low_side_pulse <= 1'b1;
        vcc_off_level <= 1'b1;
        tk(3);
        #1 chk("low_side_gate", 2'h0, 2'(low_side_gate));
        chk("bias_charge_current", 2'h1, 2'(bias_charge_current));
        tk(1);
        {low_side_pulse, vcc_off_level, vcc_on_level} <= 3'h1;
        tk(3);
        #1 chk("bias_charge_current", 2'h0, 2'(bias_charge_current));
        chk("fault_latched", 2'h1, 2'(fault_latched));
        tk(1);
        vcc_on_level <= 1'b0;
        oc_reaction_latch <= 1'b0;
        rst();
        #1 chk("fault_latched", 2'h0, 2'(fault_latched));
        // auto-recovery: gates held off, then restart on supply-on
        repeat (3) pc(1'b1, 1'b0);
        {low_side_pulse, clamp_pulse} <= 2'h3;
        tk(3);
        #1 chk("low_side_gate", 2'h0, 2'(low_side_gate));
        chk("clamp_gate", 2'h0, 2'(clamp_gate));
        tk(1);
        low_side_pulse <= 1'b0;
        tk(9);
        #1 chk("clamp_gate", 2'h0, 2'(clamp_gate));
        tk(12);
        vcc_on_level <= 1'b1;
        wait_ss();
        tk(1);
        vcc_on_level <= 1'b0;
        low_side_pulse <= 1'b1;
        tk(3);
        #1 chk("low_side_gate", 2'h1, 2'(low_side_gate));
        tk(1);
        {low_side_pulse, clamp_pulse} <= 2'h0;
        rst();
        // short trips: a clean cycle restarts the consecutive count
        pc(1'b0, 1'b1);
        pc(1'b0, 1'b1);
        pc(1'b0, 1'b0);
        pc(1'b0, 1'b1);
        pc(1'b0, 1'b1);
        #1 chk("fault_latched", 2'h0, 2'(fault_latched));
        pc(1'b0, 1'b1);
        pc(1'b0, 1'b0);
        #1 chk("fault_latched", 2'h1, 2'(fault_latched));
        rst();
        {mode_handover, low_side_pulse} <= 2'h3;
        tk(3);
        #1 chk("oc_level_sel", 2'h2, oc_level_sel);
        chk("short_level_raised", 2'h1, 2'(short_level_raised));
        tk(1);
        {mode_handover, low_side_pulse} <= 2'h0;
        tk(5);
        #1 chk("short_level_raised", 2'h1, 2'(short_level_raised));
        tk(15);
        #1 chk("oc_level_sel", 2'h0, oc_level_sel);
        tk(1);
        {active_clamp_mode, discontinuous_mode} <= 2'h2;
        tk(3);
        #1 chk("oc_level_sel", 2'h1, oc_level_sel);
        tk(1);
        high_freq_band <= 1'b1;
        tk(3);
        #1 chk("oc_level_sel", 2'h0, oc_level_sel);
        tk(1);
        {low_side_pulse, clamp_pulse} <= 2'h1;
        tk(3);
        #1 chk("clamp_gate", 2'h1, 2'(clamp_gate));
        tk(1);
        thermal_trip <= 1'b1;
        tk(4);
        #1 chk("low_side_gate", 2'h0, 2'(low_side_gate));
        chk("clamp_gate", 2'h0, 2'(clamp_gate));
        tk(1);
        thermal_trip <= 1'b0;
        tk(3);
        vcc_on_level <= 1'b1;
        wait_ss();
        end_sim();
    end
endmodule
`default_nettype wire

// >>> design/ffp_fault_fsm.sv
// ffp_fault_fsm: per-cycle current limit, overcurrent and short counters,
// handover level raise, bias cycling and latch/retry/thermal fault handling.
// assumes comparator and supply detector inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// Function
// - overcurrent trip ends low-side pulse in clamp and discontinuous modes
// - handover state selects the raised overcurrent trip level
// - overcurrent trip in a cycle flags error and adds two to counter
// - cycle without overcurrent trip subtracts one from counter
// - counter updates exactly once per switching cycle tick
// - five thousand counts is full count regardless of frequency
// - full count starts latched or auto-recovery fault per option
// - discontinuous mode selects the 784 mV overcurrent level
// - clamp mode selects a frequency-dependent falling overcurrent level
// - after short blanking, short trip ends pulse in clamp, discontinuous, skip
// - short blanking is 50 ns shorter than overcurrent blanking
// - consecutive short trips over limit latch or restart per option
// - handover raises overcurrent to 1.2 V and short to 1.4 V
// - raised levels from first handover pulse until 1 ms after handover
// - idle in fault: charge on at off level, off at on level
// - bias cycling stops on line removal, supply reset or retry expiry
// - auto-recovery holds both gates low for the whole retry interval
// - after retry interval, restart at next supply-on detection
// - latched fault lets present cycle finish, then gates stay off
// - latched fault in skip mode makes no pulses, keeps bias cycling
// - thermal trip non-latching; leaves on clear, supply reset or line removal
// - after thermal clear, fresh power-up at next supply-on detection
// - latched state holds until supply falls to reset level
module ffp_fault_fsm #(
    parameter int unsigned OC_FULL     = ffp_pkg::OC_FULL_COUNT,
    parameter int unsigned SHORT_LIMIT = ffp_pkg::SHORT_EVENT_LIMIT,
    parameter int unsigned RETRY_CYCLES = ffp_pkg::RETRY_CYC,
    parameter int unsigned HOLD_CYCLES  = ffp_pkg::HOLD_AFTER_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       low_side_pulse,
    input  wire logic       clamp_pulse,
    input  wire logic       cycle_tick,
    input  wire logic       overcurrent_trip,
    input  wire logic       short_circuit_trip,
    input  wire logic       active_clamp_mode,
    input  wire logic       discontinuous_mode,
    input  wire logic       skip_mode,
    input  wire logic       mode_handover,
    input  wire logic       high_freq_band,
    input  wire logic       vcc_on_level,
    input  wire logic       vcc_off_level,
    input  wire logic       high_voltage_input,
    input  wire logic       thermal_trip,
    input  wire logic       oc_reaction_latch,
    input  wire logic       short_reaction_latch,
    input  wire logic       short_limit_enable,
    output logic            low_side_gate,
    output logic            clamp_gate,
    output logic            bias_charge_current,
    output logic            overcurrent_error,
    output logic [1:0]      oc_level_sel,
    output logic            short_level_raised,
    output logic            per_cycle_limit,
    output logic            fault_latched,
    output logic            soft_start_req
);
    localparam int OCW = $clog2(OC_FULL + 3);
    localparam int SCW = $clog2(SHORT_LIMIT + 2);
    localparam int RTW = $clog2(RETRY_CYCLES + 1);
    localparam int HDW = $clog2(HOLD_CYCLES + 1);
    localparam int BKW = $clog2(ffp_pkg::OC_BLANK_CYC + 2);

    initial begin
        if (OC_FULL < 2 || SHORT_LIMIT < 1 || RETRY_CYCLES < 1 || HOLD_CYCLES < 1)
            $error("ffp_fault_fsm: parameter out of range");
    end

    ffp_pkg::ffp_state_t state_reg;
    logic [OCW-1:0] oc_count_reg;
    logic [SCW-1:0] short_count_reg;
    logic [RTW-1:0] retry_count_reg;
    logic [HDW-1:0] hold_count_reg;
    logic [BKW-1:0] blank_count_reg;
    logic           raised_reg;
    logic           oc_seen_reg;
    logic           short_seen_reg;
    logic           cut_reg;
    logic           pulse_d_reg;

    wire logic switching   = active_clamp_mode | discontinuous_mode;
    wire logic pulse_rise  = low_side_pulse & ~pulse_d_reg;
    wire logic oc_armed    = blank_count_reg >= BKW'(ffp_pkg::OC_BLANK_CYC);
    wire logic short_armed = blank_count_reg >= BKW'(ffp_pkg::SHORT_BLANK_CYC);
    wire logic oc_hit      = low_side_pulse & oc_armed & overcurrent_trip & switching;
    wire logic short_hit   = low_side_pulse & short_armed & short_circuit_trip
                             & (switching | skip_mode);
    wire logic oc_cycle    = oc_seen_reg | oc_hit;
    wire logic short_cycle = short_seen_reg | short_hit;
    wire logic oc_full     = oc_count_reg >= OCW'(OC_FULL);
    wire logic short_over  = short_limit_enable && (short_count_reg > SCW'(SHORT_LIMIT));
    wire logic trip_fault  = (state_reg == ffp_pkg::FFP_RUN) && (oc_full || short_over);
    wire logic trip_latch  = (oc_full && oc_reaction_latch) || (short_over && short_reaction_latch);
    wire logic gates_ok    = (state_reg == ffp_pkg::FFP_RUN) || (state_reg == ffp_pkg::FFP_LATCH_PEND);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_d_reg     <= 1'b0;
            blank_count_reg <= '0;
        end else begin
            pulse_d_reg <= low_side_pulse;
            if (!low_side_pulse)
                blank_count_reg <= '0;
            else if (!oc_armed)
                blank_count_reg <= blank_count_reg + BKW'(1);
        end
    end

    // pulse cut stays until the pulse command drops
    always_ff @(posedge clk) begin
        if (sys_rst)
            cut_reg <= 1'b0;
        else if (!low_side_pulse)
            cut_reg <= 1'b0;
        else if (oc_hit || short_hit)
            cut_reg <= 1'b1;
    end

    // per-cycle trip memories, closed at each cycle tick
    always_ff @(posedge clk) begin
        if (sys_rst || cycle_tick) begin
            oc_seen_reg    <= 1'b0;
            short_seen_reg <= 1'b0;
        end else begin
            oc_seen_reg    <= oc_cycle;
            short_seen_reg <= short_cycle;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || trip_fault)
            oc_count_reg <= '0;
        else if (cycle_tick && state_reg == ffp_pkg::FFP_RUN) begin
            if (oc_cycle)
                oc_count_reg <= oc_count_reg + OCW'(ffp_pkg::OC_UP_STEP);
            else if (oc_count_reg != '0)
                oc_count_reg <= oc_count_reg - OCW'(ffp_pkg::OC_DOWN_STEP);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            overcurrent_error <= 1'b0;
        else if (cycle_tick)
            overcurrent_error <= oc_cycle;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || trip_fault)
            short_count_reg <= '0;
        else if (cycle_tick) begin
            if (!short_cycle)
                short_count_reg <= '0;
            else if (!short_over)
                short_count_reg <= short_count_reg + SCW'(1);
        end
    end

    // raised levels from first handover pulse edge until hold time after handover
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            raised_reg     <= 1'b0;
            hold_count_reg <= '0;
        end else if (mode_handover) begin
            hold_count_reg <= '0;
            if (pulse_rise)
                raised_reg <= 1'b1;
        end else if (raised_reg) begin
            if (hold_count_reg >= HDW'(HOLD_CYCLES - 1))
                raised_reg <= 1'b0;
            else
                hold_count_reg <= hold_count_reg + HDW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oc_level_sel       <= ffp_pkg::OC_LVL_DCM;
            short_level_raised <= 1'b0;
        end else begin
            short_level_raised <= raised_reg;
            if (raised_reg)
                oc_level_sel <= ffp_pkg::OC_LVL_RAISED;
            else if (active_clamp_mode)
                oc_level_sel <= {1'b0, ~high_freq_band} & ffp_pkg::OC_LVL_ACF;
            else
                oc_level_sel <= ffp_pkg::OC_LVL_DCM;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ffp_pkg::FFP_RUN;
        end else begin
            case (state_reg)
                ffp_pkg::FFP_RUN: begin
                    if (thermal_trip)
                        state_reg <= ffp_pkg::FFP_THERMAL;
                    else if (trip_fault && trip_latch)
                        state_reg <= skip_mode ? ffp_pkg::FFP_LATCHED
                                               : ffp_pkg::FFP_LATCH_PEND;
                    else if (trip_fault)
                        state_reg <= ffp_pkg::FFP_RETRY;
                end
                ffp_pkg::FFP_LATCH_PEND: begin
                    if (cycle_tick)
                        state_reg <= ffp_pkg::FFP_LATCHED;
                end
                ffp_pkg::FFP_LATCHED: begin
                    state_reg <= ffp_pkg::FFP_LATCHED;
                end
                ffp_pkg::FFP_RETRY: begin
                    if (!high_voltage_input)
                        state_reg <= ffp_pkg::FFP_WAIT_ON;
                    else if (retry_count_reg >= RTW'(RETRY_CYCLES - 1))
                        state_reg <= ffp_pkg::FFP_WAIT_ON;
                end
                ffp_pkg::FFP_WAIT_ON: begin
                    if (vcc_on_level)
                        state_reg <= ffp_pkg::FFP_RUN;
                end
                ffp_pkg::FFP_THERMAL: begin
                    if (!thermal_trip || !high_voltage_input)
                        state_reg <= ffp_pkg::FFP_WAIT_ON;
                end
                default: state_reg <= ffp_pkg::FFP_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || state_reg != ffp_pkg::FFP_RETRY)
            retry_count_reg <= '0;
        else
            retry_count_reg <= retry_count_reg + RTW'(1);
    end

    // bias cycling: only while idle in retry or latch, and line present
    always_ff @(posedge clk) begin
        if (sys_rst || !high_voltage_input ||
            !(state_reg == ffp_pkg::FFP_RETRY || state_reg == ffp_pkg::FFP_LATCHED))
            bias_charge_current <= 1'b0;
        else if (vcc_on_level)
            bias_charge_current <= 1'b0;
        else if (vcc_off_level)
            bias_charge_current <= 1'b1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_side_gate   <= 1'b0;
            clamp_gate      <= 1'b0;
            per_cycle_limit <= 1'b0;
            fault_latched   <= 1'b0;
            soft_start_req  <= 1'b0;
        end else begin
            low_side_gate   <= gates_ok & low_side_pulse & ~cut_reg & ~oc_hit & ~short_hit;
            clamp_gate      <= gates_ok & clamp_pulse & ~low_side_pulse;
            per_cycle_limit <= cut_reg | oc_hit | short_hit;
            fault_latched   <= (state_reg == ffp_pkg::FFP_LATCHED) || (state_reg == ffp_pkg::FFP_LATCH_PEND);
            soft_start_req  <= (state_reg == ffp_pkg::FFP_WAIT_ON) && vcc_on_level;
        end
    end
endmodule

`default_nettype wire

// >>> design/ffp_pkg.sv
// ffp_pkg: constants shared by the flyback fault supervision block.
// assumes a 100 MHz system clock; analog levels are carried as select codes only.
package ffp_pkg;
    localparam int unsigned CLK_MHZ            = 100;
    localparam int unsigned OC_FULL_COUNT      = 5000;
    localparam int unsigned OC_UP_STEP         = 2;
    localparam int unsigned OC_DOWN_STEP       = 1;
    localparam int unsigned OC_BLANK_NS        = 150;
    localparam int unsigned SHORT_BLANK_LEAD_NS = 50;
    localparam int unsigned SHORT_BLANK_NS     = OC_BLANK_NS - SHORT_BLANK_LEAD_NS;
    localparam int unsigned OC_BLANK_CYC       = (OC_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SHORT_BLANK_CYC    = (SHORT_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned HOLD_AFTER_US      = 1000;
    localparam int unsigned HOLD_AFTER_CYC     = HOLD_AFTER_US * CLK_MHZ;
    localparam int unsigned RETRY_MS           = 1600;
    localparam int unsigned RETRY_CYC          = RETRY_MS * 1000 * CLK_MHZ;
    localparam int unsigned SHORT_EVENT_LIMIT  = 2;
    // overcurrent level select codes
    localparam logic [1:0] OC_LVL_DCM    = 2'h0;
    localparam logic [1:0] OC_LVL_ACF    = 2'h1;
    localparam logic [1:0] OC_LVL_RAISED = 2'h2;
    typedef enum logic [2:0] {
        FFP_RUN,
        FFP_LATCH_PEND,
        FFP_LATCHED,
        FFP_RETRY,
        FFP_WAIT_ON,
        FFP_THERMAL
    } ffp_state_t;
endpackage
